// ---- rtl/uart_icr_defs.vh ----
// Constants for the serial port interrupt clear logic
`ifndef UART_ICR_DEFS_VH
`define UART_ICR_DEFS_VH
`define ADDR_INTERRUPT_CLEAR 8'h44
`define ADDR_RAW_STATUS      8'h3c
`define ADDR_MASK            8'h38
`define ADDR_MASKED_STATUS   8'h40
`define NUM_SRC              11
`define BIT_RING             0
`define BIT_CTS              1
`define BIT_CARRIER          2
`define BIT_DSR              3
`define BIT_RECEIVE          4
`define BIT_TRANSMIT         5
`define BIT_RX_TIMEOUT       6
`define BIT_FRAMING          7
`define BIT_PARITY           8
`define BIT_BREAK            9
`define BIT_OVERRUN          10
`define MODEM_MASK           11'h00f
`define STATUS_RESET         11'h000
`define RX_TIMEOUT_TICKS     9'h1ff
`define BAUD_DIV_DEFAULT     16'h0016
`endif

// ---- rtl/uart_icr_flag.v ----
// One sticky interrupt status flag with set-over-clear
`timescale 1ns/1ps
`default_nettype none
module uart_icr_flag #(
  parameter RESET_CLEARS = 1
) (
  input  wire clk_i,
  input  wire rstn_i,
  input  wire set_i,
  input  wire clear_i,
  output reg  flag_o
);
  always @(posedge clk_i) begin
    if (!rstn_i && RESET_CLEARS) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clear_i) begin
      flag_o <= 1'b0;
    end
  end
endmodule // uart_icr_flag
`default_nettype wire

// ---- rtl/uart_icr_timeout.v ----
// Receive timeout counter on the baud_x16 tick
`timescale 1ns/1ps
`include "uart_icr_defs.vh"
`default_nettype none
module uart_icr_timeout (
  input  wire clk_i,
  input  wire rstn_i,
  input  wire baud_x16_tick_i,
  input  wire rx_store_i,
  input  wire rx_read_i,
  output reg  timeout_o
);
  reg  [8:0] count_q;
  reg        armed_q;
  always @(posedge clk_i) begin
    timeout_o <= 1'b0;
    if (!rstn_i) begin
      count_q <= 9'h000;
      armed_q <= 1'b0;
    end else if (rx_read_i) begin
      count_q <= 9'h000;
      armed_q <= 1'b0;
    end else if (rx_store_i) begin
      count_q <= 9'h000;
      armed_q <= 1'b1;
    end else if (armed_q && baud_x16_tick_i) begin
      if (count_q == `RX_TIMEOUT_TICKS - 9'h001) begin
        timeout_o <= 1'b1;
        armed_q   <= 1'b0;
      end
      count_q <= count_q + 9'h001;
    end
  end
endmodule // uart_icr_timeout
`default_nettype wire

// ---- rtl/uart_interrupt_clear.v ----
// Interrupt status, mask and write-only clear register of the serial port
`timescale 1ns/1ps
`include "uart_icr_defs.vh"
`default_nettype none
module uart_interrupt_clear #(
  parameter BAUD_DIV = 16'h0016
) (
  input  wire        clk_i,
  input  wire        rstn_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  input  wire        overrun_i,
  input  wire        break_i,
  input  wire        parity_i,
  input  wire        framing_i,
  input  wire        transmit_i,
  input  wire        receive_i,
  input  wire        rx_store_i,
  input  wire        rx_read_i,
  input  wire        dsr_line_i,
  input  wire        carrier_line_i,
  input  wire        cts_line_i,
  input  wire        ring_line_i,
  output reg         irq_o
);
  reg  [15:0] div_q;
  reg         baud_x16_tick_q;
  reg  [3:0]  modem_s1_q;
  reg  [3:0]  modem_s2_q;
  reg  [3:0]  modem_s3_q;
  reg  [10:0] mask_q;
  wire [10:0] status;
  wire [10:0] set_vec;
  wire [10:0] clr_vec;
  wire        timeout_pulse;
  wire        clr_wr;

  // Baud x16 tick divider
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      div_q           <= 16'h0000;
      baud_x16_tick_q <= 1'b0;
    end else if (div_q == BAUD_DIV - 16'h0001) begin
      div_q           <= 16'h0000;
      baud_x16_tick_q <= 1'b1;
    end else begin
      div_q           <= div_q + 16'h0001;
      baud_x16_tick_q <= 1'b0;
    end
  end

  // Modem lines are pins: synchronise, then detect any change
  always @(posedge clk_i) begin
    modem_s1_q <= {dsr_line_i, carrier_line_i, cts_line_i, ring_line_i};
    modem_s2_q <= modem_s1_q;
    modem_s3_q <= modem_s2_q;
  end

  uart_icr_timeout u_timeout (
    .clk_i           (clk_i),
    .rstn_i          (rstn_i),
    .baud_x16_tick_i (baud_x16_tick_q),
    .rx_store_i      (rx_store_i),
    .rx_read_i       (rx_read_i),
    .timeout_o       (timeout_pulse)
  );

  assign set_vec = {overrun_i, break_i, parity_i, framing_i, timeout_pulse,
                    transmit_i, receive_i, modem_s2_q ^ modem_s3_q};
  assign clr_wr  = wr_i && (addr_i == `ADDR_INTERRUPT_CLEAR);
  // Only ones clear; zeros and bits 31..11 are ignored
  assign clr_vec = clr_wr ? wdata_i[10:0] : 11'h000;

  genvar g;
  generate
    for (g = 0; g < `NUM_SRC; g = g + 1) begin : g_flag
      uart_icr_flag #(
        .RESET_CLEARS (((`MODEM_MASK >> g) & 1) == 0)
      ) u_flag (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .set_i   (set_vec[g]),
        .clear_i (clr_vec[g]),
        .flag_o  (status[g])
      );
    end
  endgenerate

  // Register access; the clear register reads as zero
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      mask_q  <= 11'h000;
      rdata_o <= 32'h00000000;
      irq_o   <= 1'b0;
    end else begin
      if (wr_i && addr_i == `ADDR_MASK) begin
        mask_q <= wdata_i[10:0];
      end
      irq_o <= |(status & mask_q);
      if (!rd_i) begin
        rdata_o <= 32'h00000000;
      end else if (addr_i == `ADDR_RAW_STATUS) begin
        rdata_o <= {21'h000000, status};
      end else if (addr_i == `ADDR_MASK) begin
        rdata_o <= {21'h000000, mask_q};
      end else if (addr_i == `ADDR_MASKED_STATUS) begin
        rdata_o <= {21'h000000, status & mask_q};
      end else begin
        rdata_o <= 32'h00000000;
      end
    end
  end
endmodule // uart_interrupt_clear
`default_nettype wire

// ---- testbench/uart_icr_props.sv ----
// Port checker of the clear block
`timescale 1ns/1ps
`default_nettype none
module uart_icr_props (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        overrun_i,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire clr = wr_i && addr_i == 8'h44;
  wire z   = clr && irq_o;
  sequence clr_ov;
    clr && wdata_i[10] && !overrun_i ##1 !overrun_i ##1 rd_i && addr_i == 8'h3c;
  endsequence
  a_icr_rd_zero: assert property (rd_i && addr_i == 8'h44 |=> !rdata_o)
    else $error("icr read");
  a_rd_idle: assert property (!rd_i |=> !rdata_o)
    else $error("idle read");
  a_zero_wr_keep: assert property (z && !wdata_i && !$past(wr_i) |=> irq_o)
    else $error("zero write");
  a_hi_wr_keep: assert property (z && !wdata_i[10:0] && !$past(wr_i) |=> irq_o)
    else $error("high write");
  a_ov_cleared: assert property (clr_ov |=> !rdata_o[10])
    else $error("overrun");
  a_reset_quiet: assert property (disable iff (1'h0) !rstn_i |=> !irq_o && !rdata_o)
    else $error("reset");
endmodule // uart_icr_props
bind uart_interrupt_clear uart_icr_props props_u (.clk_i(clk_i), .rstn_i(rstn_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .overrun_i(overrun_i), .irq_o(irq_o));
`default_nettype wire

// ---- testbench/testbench.sv ----
// Bench for the clear block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_i = 1'h0, rstn_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0, st = 1'h0, irq_o;
  logic        rx = 1'h0;
  logic [7:0]  addr_i = 8'h0;
  logic [5:0]  ev = 6'h0;
  logic [3:0]  md = 4'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o, r, e;
  int          fail_count = 0, n_tests = 0;
  always #12.5 clk_i = ~clk_i;
  uart_interrupt_clear #(.BAUD_DIV(16'h2)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .overrun_i(ev[5]), .break_i(ev[4]), .parity_i(ev[3]), .framing_i(ev[2]),
    .transmit_i(ev[1]), .receive_i(ev[0]), .rx_store_i(st), .rx_read_i(rx),
    .dsr_line_i(md[3]), .carrier_line_i(md[2]), .cts_line_i(md[1]), .ring_line_i(md[0]),
    .irq_o(irq_o));
  task chk(input logic [31:0] g, x);
    n_tests++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected at %0t: %h", $time, g);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'h0;
    rd_i <= 1'h0;
    #1 r = rdata_o;
  endtask
  task t_reset;
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'h1;
    bus(1'h0, 8'h3c, 32'h0);
    chk(r >> 4, 32'h0);
    bus(1'h1, 8'h38, 32'h7ff);
  endtask
  task t_set_all;
    @(posedge clk_i);
    ev <= 6'h3f;
    md <= 4'hf;
    st <= 1'h1;
    @(posedge clk_i);
    ev <= 6'h0;
    st <= 1'h0;
    repeat (1000) @(posedge clk_i);
    bus(1'h0, 8'h3c, 32'h0);
    chk(r, 32'h7bf);
    repeat (40) @(posedge clk_i);
    bus(1'h0, 8'h3c, 32'h0);
    chk(r, 32'h7ff);
    bus(1'h1, 8'h44, 32'hfffff800);
    bus(1'h1, 8'h44, 32'h0);
    bus(1'h0, 8'h40, 32'h0);
    chk(r, 32'h7ff);
    bus(1'h0, 8'h44, 32'h0);
    chk(r, 32'h0);
  endtask
  task t_clear_each;
    e = 32'h7ff;
    for (int n = 10; n >= 0; n--) begin
      e[n] = 1'h0;
      bus(1'h1, 8'h44, 32'h1 << n);
      bus(1'h0, 8'h3c, 32'h0);
      chk(r, e);
    end
    chk({31'h0, irq_o}, 32'h0);
    // A read right after the store disarms the timeout
    @(posedge clk_i);
    st <= 1'h1;
    @(posedge clk_i);
    st <= 1'h0;
    rx <= 1'h1;
    @(posedge clk_i);
    rx <= 1'h0;
    repeat (1040) @(posedge clk_i);
    bus(1'h0, 8'h3c, 32'h0);
    chk(r, 32'h0);
  endtask
  task conclude;
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    t_reset;
    t_set_all;
    t_clear_each;
    conclude;
  end
endmodule // testbench
`default_nettype wire
